// ---- cpu_flags_regfile_stack.sv ----
// Core architectural state: flags, working registers, pointers, stack pointer, page and temp byte
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_cfg.svh"

module cpu_flags_regfile_stack #(
    parameter int PAGE_BITS = 8
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire cpu_core_pkg::aluFlags_t alu,
    input  wire logic [4:0]              rdAddrA,
    input  wire logic [4:0]              rdAddrB,
    input  wire logic [3:0]              rdPair,
    output logic [7:0]                   opA,
    output logic [7:0]                   opB,
    output logic [15:0]                  op16,
    input  wire cpu_core_pkg::write8_t   wr8,
    input  wire cpu_core_pkg::write16_t  wr16,
    input  wire cpu_core_pkg::busReq_t   bus,
    output logic [7:0]                   busRdata,
    output logic                         busHit,
    input  wire cpu_core_pkg::ptrReq_t   ptr,
    output logic [15:0]                  ptrAddr,
    input  wire cpu_core_pkg::stackOp_t  stackOp,
    output logic [15:0]                  stackAddr,
    input  wire cpu_core_pkg::pmReq_t    pm,
    output logic [23:0]                  pmAddr,
    output logic [7:0]                   statusRegister,
    output logic [15:0]                  stackPointer
);

    // ************************************************************
    // Constants and checks
    // ************************************************************
    localparam logic [15:0] SP_HI_ADDR = `CFG_SP_ADDR + `CFG_SP_HI_STEP;
    localparam logic [7:0]  PAGE_MASK  = 8'((9'h001 << PAGE_BITS) - 9'h001);

    generate
        if (PAGE_BITS < 1 || PAGE_BITS > 8) begin : g_bad_page
            $error("PAGE_BITS must lie between 1 and 8");
        end
    endgenerate

    cpu_core_pkg::coreState_t st;
    cpu_core_pkg::coreState_t next_st;

    logic [15:0] dAddr;
    logic [4:0]  ptrIdx;
    logic [15:0] ptrVal;
    logic [15:0] zPtr;
    logic        ptrGo;

    // ************************************************************
    // Address decode and read ports
    // ************************************************************
    // Port instructions carry six address bits, so they never reach the extended range
    assign dAddr  = bus.io ? (16'(bus.addr[5:0]) + `CFG_IO_TO_DATA) : bus.addr;
    assign ptrIdx = `CFG_PTR_BASE + {2'h0, ptr.sel, 1'b0};
    assign ptrVal = {st.gpr[ptrIdx + 5'h01], st.gpr[ptrIdx]};
    assign zPtr   = {st.gpr[31], st.gpr[30]};
    assign ptrGo  = ptr.valid && (ptr.sel != 2'h3);

    assign opA  = st.gpr[rdAddrA];
    assign opB  = st.gpr[rdAddrB];
    assign op16 = {st.gpr[{rdPair, 1'b1}], st.gpr[{rdPair, 1'b0}]};

    always_comb begin
        statusRegister = st.status_register;
        statusRegister[`CFG_BIT_S] = st.status_register[`CFG_BIT_N] ^ st.status_register[`CFG_BIT_V];
    end

    assign stackPointer = {2'b00, st.sp};
    assign busRdata     = st.rdata;
    assign busHit       = st.hit;
    assign ptrAddr      = st.ptrAddr;
    assign stackAddr    = st.stackAddr;
    assign pmAddr       = st.pmAddr;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.hit = 1'b0;

        // Result writes; the 16-bit port lands after the 8-bit one
        if (wr8.en) begin
            next_st.gpr[wr8.addr] = wr8.data;
        end
        if (wr16.en) begin
            next_st.gpr[{wr16.pair, 1'b0}] = wr16.data[7:0];
            next_st.gpr[{wr16.pair, 1'b1}] = wr16.data[15:8];
        end

        // Register reads over data space
        if (bus.rd) begin
            next_st.hit   = 1'b1;
            next_st.rdata = 8'h00;
            if (dAddr < 16'(`CFG_GPR_COUNT)) begin
                next_st.rdata = st.gpr[dAddr[4:0]];
            end else begin
                case (dAddr)
                    `CFG_STATUS_REGISTER_ADDR: next_st.rdata = statusRegister;
                    `CFG_SP_ADDR: begin
                        next_st.rdata = st.sp[7:0];
                        next_st.temp  = {2'b00, st.sp[13:8]};
                    end
                    SP_HI_ADDR:     next_st.rdata = st.temp;
                    `CFG_PAGE_ADDR: next_st.rdata = st.page & PAGE_MASK;
                    `CFG_TEMP_ADDR: next_st.rdata = st.temp;
                    default:        next_st.hit   = 1'b0;
                endcase
            end
        end

        // Register writes over data space
        if (bus.wr) begin
            if (dAddr < 16'(`CFG_GPR_COUNT)) begin
                next_st.gpr[dAddr[4:0]] = bus.wdata;
            end else begin
                case (dAddr)
                    `CFG_STATUS_REGISTER_ADDR: next_st.status_register  = bus.wdata;
                    `CFG_SP_ADDR:   next_st.temp  = bus.wdata;
                    SP_HI_ADDR:     next_st.sp    = {bus.wdata[5:0], st.temp};
                    `CFG_PAGE_ADDR: next_st.page  = bus.wdata & PAGE_MASK;
                    `CFG_TEMP_ADDR: next_st.temp  = bus.wdata;
                    default: ;
                endcase
            end
        end

        // Flag updates win over a software write in the same cycle
        if (alu.updH) begin
            next_st.status_register[`CFG_BIT_H] = alu.h;
        end
        if (alu.updV) begin
            next_st.status_register[`CFG_BIT_V] = alu.v;
        end
        if (alu.updN) begin
            next_st.status_register[`CFG_BIT_N] = alu.result[7];
        end
        if (alu.updZ) begin
            next_st.status_register[`CFG_BIT_Z] = (alu.result == 8'h00);
        end
        if (alu.updC) begin
            next_st.status_register[`CFG_BIT_C] = alu.c;
        end
        // Bit four is never stored; it is formed on read
        next_st.status_register[`CFG_BIT_S] = 1'b0;

        // Pointer addressing; pointer update lands last
        if (ptrGo) begin
            unique case (ptr.mode)
                cpu_core_pkg::PTR_PLAIN: begin
                    next_st.ptrAddr = ptrVal;
                end
                cpu_core_pkg::PTR_DISP: begin
                    next_st.ptrAddr = ptrVal + 16'(ptr.disp);
                end
                cpu_core_pkg::PTR_POSTINC: begin
                    next_st.ptrAddr = ptrVal;
                    {next_st.gpr[ptrIdx + 5'h01], next_st.gpr[ptrIdx]} = ptrVal + 16'h0001;
                end
                cpu_core_pkg::PTR_PREDEC: begin
                    next_st.ptrAddr = ptrVal - 16'h0001;
                    {next_st.gpr[ptrIdx + 5'h01], next_st.gpr[ptrIdx]} = ptrVal - 16'h0001;
                end
            endcase
        end

        // Stack: a stack operation overrides a software write of the pointer
        unique case (stackOp)
            cpu_core_pkg::STK_NONE: ;
            cpu_core_pkg::STK_PUSH1: begin
                next_st.stackAddr = {2'b00, st.sp};
                next_st.sp = st.sp - 14'h0001;
            end
            cpu_core_pkg::STK_PUSH2: begin
                next_st.stackAddr = {2'b00, st.sp};
                next_st.sp = st.sp - 14'h0002;
            end
            cpu_core_pkg::STK_POP1: begin
                next_st.stackAddr = {2'b00, st.sp + 14'h0001};
                next_st.sp = st.sp + 14'h0001;
            end
            cpu_core_pkg::STK_POP2: begin
                next_st.stackAddr = {2'b00, st.sp + 14'h0001};
                next_st.sp = st.sp + 14'h0002;
            end
            default: ;
        endcase

        // Program memory address; the plain load ignores the page
        if (pm.valid) begin
            if (pm.ext) begin
                next_st.pmAddr = {st.page & PAGE_MASK, zPtr};
            end else begin
                next_st.pmAddr = {8'h00, zPtr};
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st.gpr       <= '0;
            st.status_register      <= `CFG_STATUS_REGISTER_RESET;
            st.sp        <= `CFG_SP_RESET;
            st.page      <= `CFG_PAGE_RESET;
            st.temp      <= 8'h00;
            st.rdata     <= 8'h00;
            st.hit       <= 1'b0;
            st.ptrAddr   <= 16'h0000;
            st.stackAddr <= 16'h0000;
            st.pmAddr    <= 24'h000000;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic quiet;
    assign quiet = !wr8.en && !wr16.en && !bus.wr;

    a_sign_on_read: assert property (bus.rd && dAddr == `CFG_STATUS_REGISTER_ADDR |=>
        busRdata[4] == (busRdata[3] ^ busRdata[2]))
        else $error("sign flag not negative xor overflow");

    a_zero_flag: assert property (alu.updZ |=>
        st.status_register[`CFG_BIT_Z] == ($past(alu.result) == 8'h00))
        else $error("zero flag wrong");

    a_neg_flag: assert property (alu.updN |=> st.status_register[`CFG_BIT_N] == $past(alu.result[7]))
        else $error("negative flag wrong");

    a_push_one: assert property (stackOp == cpu_core_pkg::STK_PUSH1 |=>
        st.sp == $past(st.sp) - 14'h0001 && stackAddr == {2'b00, $past(st.sp)})
        else $error("push did not write then decrement");

    a_pop_two: assert property (stackOp == cpu_core_pkg::STK_POP2 |=>
        st.sp == $past(st.sp) + 14'h0002 && stackAddr == {2'b00, $past(st.sp) + 14'h0001})
        else $error("return did not add two");

    a_high_commit: assert property (bus.wr && dAddr == SP_HI_ADDR && stackOp == cpu_core_pkg::STK_NONE |=>
        st.sp == {$past(bus.wdata[5:0]), $past(st.temp)})
        else $error("high write did not commit temp");

    a_low_latch: assert property (bus.rd && dAddr == `CFG_SP_ADDR && !bus.wr |=>
        st.temp == {2'b00, $past(st.sp[13:8])})
        else $error("low read did not latch high byte");

    a_ext_address: assert property (pm.valid && pm.ext |=>
        pmAddr == {$past(st.page) & PAGE_MASK, $past(zPtr)})
        else $error("extended address not page and Z");

    a_plain_address: assert property (pm.valid && !pm.ext |=> pmAddr[23:16] == 8'h00)
        else $error("plain load used page");

    a_post_increment: assert property (ptrGo && ptr.mode == cpu_core_pkg::PTR_POSTINC && quiet |=>
        ptrAddr == $past(ptrVal) &&
        {st.gpr[$past(ptrIdx) + 5'h01], st.gpr[$past(ptrIdx)]} == $past(ptrVal) + 16'h0001)
        else $error("post-increment wrong");

    a_carry_flag: assert property (alu.updC |=> st.status_register[`CFG_BIT_C] == $past(alu.c))
        else $error("carry flag wrong");

    a_overflow_flag: assert property (alu.updV |=> st.status_register[`CFG_BIT_V] == $past(alu.v))
        else $error("overflow flag wrong");

    a_half_carry: assert property (alu.updH |=> st.status_register[`CFG_BIT_H] == $past(alu.h))
        else $error("half carry flag wrong");

    a_sp_top_bits: assert property (stackPointer[15:14] == 2'b00)
        else $error("stack pointer top bits not zero");

    a_push_two: assert property (stackOp == cpu_core_pkg::STK_PUSH2 |=>
        st.sp == $past(st.sp) - 14'h0002 && stackAddr == {2'b00, $past(st.sp)})
        else $error("call did not subtract two");

    a_pop_one: assert property (stackOp == cpu_core_pkg::STK_POP1 |=>
        st.sp == $past(st.sp) + 14'h0001 && stackAddr == {2'b00, $past(st.sp) + 14'h0001})
        else $error("pop did not increment first");

    a_pre_decrement: assert property (ptrGo && ptr.mode == cpu_core_pkg::PTR_PREDEC && quiet |=>
        ptrAddr == $past(ptrVal) - 16'h0001 &&
        {st.gpr[$past(ptrIdx) + 5'h01], st.gpr[$past(ptrIdx)]} == $past(ptrVal) - 16'h0001)
        else $error("pre-decrement wrong");

    a_disp_address: assert property (ptrGo && ptr.mode == cpu_core_pkg::PTR_DISP |=>
        ptrAddr == $past(ptrVal) + 16'($past(ptr.disp)))
        else $error("displacement address wrong");

    a_register_read: assert property (bus.rd && dAddr < 16'(`CFG_GPR_COUNT) |=>
        busHit && busRdata == $past(st.gpr[dAddr[4:0]]))
        else $error("register not readable in data space");

    a_port_reach: assert property (bus.io |->
        dAddr >= `CFG_IO_TO_DATA && dAddr < `CFG_EXT_IO_BASE)
        else $error("port address escaped its window");

    a_page_unused: assert property (bus.rd && dAddr == `CFG_PAGE_ADDR |=> (busRdata & ~PAGE_MASK) == 8'h00)
        else $error("unused page bits not zero");

    a_temp_write: assert property (bus.wr && dAddr == `CFG_TEMP_ADDR |=> st.temp == $past(bus.wdata))
        else $error("temp byte not written");

    c_push_pop: cover property (stackOp == cpu_core_pkg::STK_PUSH2 ##[1:8] stackOp == cpu_core_pkg::STK_POP2);
    c_sp_write: cover property (bus.wr && dAddr == `CFG_SP_ADDR ##1 bus.wr && dAddr == SP_HI_ADDR);
    c_ext_load: cover property (pm.valid && pm.ext && st.page != 8'h00);
    c_predec: cover property (ptrGo && ptr.mode == cpu_core_pkg::PTR_PREDEC);

endmodule : cpu_flags_regfile_stack

`default_nettype wire

// ---- cpu_core_cfg.svh ----
// Offsets, bit positions, reset values and address-space constants of the core state block
`ifndef CPU_CORE_CFG_SVH
`define CPU_CORE_CFG_SVH

`define CFG_GPR_COUNT     32
`define CFG_IO_TO_DATA    16'h0020
`define CFG_IO_LAST       6'h3F
`define CFG_EXT_IO_BASE   16'h0060
`define CFG_STATUS_REGISTER_ADDR     16'h005F
`define CFG_SP_ADDR       16'h005D
`define CFG_SP_HI_STEP    16'h0001
`define CFG_PAGE_ADDR     16'h005B
`define CFG_TEMP_ADDR     16'h005A
`define CFG_PTR_BASE      5'h1A
`define CFG_STATUS_REGISTER_RESET    8'h00
`define CFG_SP_RESET      14'h10FF
`define CFG_PAGE_RESET    8'h00
`define CFG_BIT_C         0
`define CFG_BIT_Z         1
`define CFG_BIT_N         2
`define CFG_BIT_V         3
`define CFG_BIT_S         4
`define CFG_BIT_H         5

`endif

// ---- cpu_core_pkg.sv ----
// Types shared by the core state block and its callers
package cpu_core_pkg;

    typedef enum logic [2:0] {
        STK_NONE  = 3'h0,
        STK_PUSH1 = 3'h1,
        STK_POP1  = 3'h3,
        STK_PUSH2 = 3'h2,
        STK_POP2  = 3'h6
    } stackOp_t;

    typedef enum logic [1:0] {
        PTR_PLAIN   = 2'h0,
        PTR_DISP    = 2'h1,
        PTR_POSTINC = 2'h3,
        PTR_PREDEC  = 2'h2
    } ptrMode_t;

    typedef struct packed {
        logic       updH;
        logic       updV;
        logic       updN;
        logic       updZ;
        logic       updC;
        logic       h;
        logic       v;
        logic       c;
        logic [7:0] result;
    } aluFlags_t;

    typedef struct packed {
        logic       en;
        logic [4:0] addr;
        logic [7:0] data;
    } write8_t;

    typedef struct packed {
        logic        en;
        logic [3:0]  pair;
        logic [15:0] data;
    } write16_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        io;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } busReq_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] sel;
        ptrMode_t   mode;
        logic [5:0] disp;
    } ptrReq_t;

    typedef struct packed {
        logic valid;
        logic ext;
    } pmReq_t;

    typedef struct packed {
        logic [31:0][7:0] gpr;
        logic [7:0]       status_register;
        logic [13:0]      sp;
        logic [7:0]       page;
        logic [7:0]       temp;
        logic [7:0]       rdata;
        logic             hit;
        logic [15:0]      ptrAddr;
        logic [15:0]      stackAddr;
        logic [23:0]      pmAddr;
    } coreState_t;

endpackage : cpu_core_pkg

// ---- exec_model.sv ----
// Execute-stage model issuing register, stack, pointer and program-address requests
`timescale 1ns/1ps
`default_nettype none
module exec_model (
    input  wire logic                  clk,
    input  wire logic [7:0]            busRdata,
    input  wire logic                  busHit,
    output var cpu_core_pkg::busReq_t  bus,
    output var cpu_core_pkg::stackOp_t stackOp,
    output var cpu_core_pkg::ptrReq_t  ptr,
    output var cpu_core_pkg::pmReq_t   pm
);
    // Every request rises after a falling edge and is held over exactly one rising edge.
    // Released qualifiers other than the pointer mode go to inverted values so a design cannot lean on stale ones.
    initial begin
        bus = '0;
        stackOp = cpu_core_pkg::STK_NONE;
        ptr = '0;
        pm = '0;
    end

    // Low byte always goes before high byte, and no access is interleaved
    task automatic busWrite(input logic io, input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk);
        bus <= '{rd: 1'b0, wr: 1'b1, io: io, addr: addr, wdata: data};
        @(negedge clk);
        bus <= '{rd: 1'b0, wr: 1'b0, io: ~io, addr: ~addr, wdata: ~data};
    endtask : busWrite

    task automatic busRead(input logic io, input logic [15:0] addr, output logic [7:0] data,
                           output logic hit);
        @(negedge clk);
        bus <= '{rd: 1'b1, wr: 1'b0, io: io, addr: addr, wdata: 8'h00};
        @(negedge clk);
        bus <= '{rd: 1'b0, wr: 1'b0, io: ~io, addr: ~addr, wdata: 8'hFF};
        data = busRdata;
        hit = busHit;
    endtask : busRead

    task automatic stackStep(input cpu_core_pkg::stackOp_t op);
        @(negedge clk);
        stackOp <= op;
        @(negedge clk);
        stackOp <= cpu_core_pkg::STK_NONE;
    endtask : stackStep

    task automatic ptrStep(input cpu_core_pkg::ptrMode_t mode, input logic [5:0] disp);
        @(negedge clk);
        ptr <= '{valid: 1'b1, sel: 2'h0, mode: mode, disp: disp};
        @(negedge clk);
        ptr <= '{valid: 1'b0, sel: 2'h3, mode: mode, disp: ~disp};
    endtask : ptrStep

    task automatic pmStep(input logic ext);
        @(negedge clk);
        pm <= '{valid: 1'b1, ext: ext};
        @(negedge clk);
        pm <= '{valid: 1'b0, ext: ~ext};
    endtask : pmStep
endmodule : exec_model
`default_nettype wire

// ---- cpu_flags_regfile_stack_tb.sv ----
// Self-checking bench for the core state block
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_regfile_stack_tb;
    typedef struct packed {logic [7:0] result; logic h; logic v; logic c; logic [7:0] status;} flagRow_t;
    typedef struct packed {cpu_core_pkg::ptrMode_t mode; logic [5:0] disp; logic [15:0] addr; logic [15:0] x;} ptrRow_t;
    // Narrow page register so the unused top bit is exercised
    localparam int PAGE_W = 7;
    logic                    clk = 1'b0;
    logic                    reset_n = 1'b0;
    cpu_core_pkg::aluFlags_t alu = '0;
    logic [4:0]              rdAddrA = 5'h00;
    logic [4:0]              rdAddrB = 5'h00;
    logic [3:0]              rdPair = 4'h0;
    cpu_core_pkg::write8_t   wr8 = '0;
    cpu_core_pkg::write16_t  wr16 = '0;
    cpu_core_pkg::busReq_t   bus;
    cpu_core_pkg::ptrReq_t   ptr;
    cpu_core_pkg::stackOp_t  stackOp;
    cpu_core_pkg::pmReq_t    pm;
    logic [7:0]              opA, opB, busRdata, statusRegister;
    logic [15:0]             op16, ptrAddr, stackAddr, stackPointer, sp;
    logic [23:0]             pmAddr;
    logic                    busHit;
    int                      errors = 0;
    int                      compares = 0;
    int                      cycles = 0;
    flagRow_t rows [5] = '{'{8'h00, 1'b0, 1'b0, 1'b0, 8'h02}, '{8'h80, 1'b0, 1'b0, 1'b0, 8'h14},
                           '{8'h80, 1'b0, 1'b1, 1'b0, 8'h0C}, '{8'h01, 1'b1, 1'b1, 1'b1, 8'h39},
                           '{8'hFF, 1'b0, 1'b0, 1'b1, 8'h15}};
    ptrRow_t ptrRows [4] = '{'{cpu_core_pkg::PTR_POSTINC, 6'h00, 16'h0100, 16'h0101},
                             '{cpu_core_pkg::PTR_PREDEC, 6'h00, 16'h0100, 16'h0100},
                             '{cpu_core_pkg::PTR_DISP, 6'h3F, 16'h013F, 16'h0100},
                             '{cpu_core_pkg::PTR_PLAIN, 6'h00, 16'h0100, 16'h0100}};
    cpu_core_pkg::stackOp_t ops [4] = '{cpu_core_pkg::STK_PUSH1, cpu_core_pkg::STK_PUSH2,
                                        cpu_core_pkg::STK_POP1, cpu_core_pkg::STK_POP2};
    logic [15:0] spStep [4] = '{16'hFFFF, 16'hFFFE, 16'h0001, 16'h0002};

    always #4 clk = ~clk;

    cpu_flags_regfile_stack #(.PAGE_BITS(PAGE_W)) cpu_flags_regfile_stack_inst (
        .clk(clk), .reset_n(reset_n), .alu(alu), .rdAddrA(rdAddrA), .rdAddrB(rdAddrB),
        .rdPair(rdPair), .opA(opA), .opB(opB), .op16(op16), .wr8(wr8), .wr16(wr16), .bus(bus),
        .busRdata(busRdata), .busHit(busHit), .ptr(ptr), .ptrAddr(ptrAddr), .stackOp(stackOp),
        .stackAddr(stackAddr), .pm(pm), .pmAddr(pmAddr), .statusRegister(statusRegister),
        .stackPointer(stackPointer));

    exec_model exec_model_inst (.clk(clk), .busRdata(busRdata), .busHit(busHit), .bus(bus),
        .stackOp(stackOp), .ptr(ptr), .pm(pm));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string name, input logic [23:0] expected, input logic [23:0] seen);
        compares++;
        if (seen !== expected) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, expected, seen);
        end
    endtask : check

    task automatic readCheck(input string name, input logic io, input logic [15:0] addr,
                             input logic expHit, input logic [7:0] expData);
        logic [7:0] data;
        logic       hit;
        exec_model_inst.busRead(io, addr, data, hit);
        check(name, {15'h0000, expHit, expData}, {15'h0000, hit, data});
    endtask : readCheck

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Whole run needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            @(negedge clk);
            alu <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, rows[i].h, rows[i].v, rows[i].c, rows[i].result};
            @(negedge clk);
            alu <= '0;
            check("status flags", {16'h0000, rows[i].status}, {16'h0000, statusRegister});
        end
        // ****************************************************************
        // Reset values and register access
        // ****************************************************************
        reset_n <= 1'b0;
        @(negedge clk);
        reset_n <= 1'b1;
        check("status reset", 24'h000000, {16'h0000, statusRegister});
        check("sp reset", 24'h0010FF, {8'h00, stackPointer});
        readCheck("page reset", 1'b0, 16'h005B, 1'b1, 8'h00);
        readCheck("status port", 1'b1, 16'h003F, 1'b1, 8'h00);
        exec_model_inst.busWrite(1'b0, 16'h005D, 8'h34);
        check("sp after low only", 24'h0010FF, {8'h00, stackPointer});
        exec_model_inst.busWrite(1'b0, 16'h005E, 8'hFF);
        check("sp write", 24'h003F34, {8'h00, stackPointer});
        readCheck("sp low", 1'b0, 16'h005D, 1'b1, 8'h34);
        readCheck("temp direct", 1'b0, 16'h005A, 1'b1, 8'h3F);
        exec_model_inst.busWrite(1'b1, 16'h003A, 8'h12);
        readCheck("sp high from temp", 1'b1, 16'h003E, 1'b1, 8'h12);
        readCheck("sp low port", 1'b1, 16'h003D, 1'b1, 8'h34);
        // Stack walk from a known pointer, both widths, back to its start
        sp = 16'h3F34;
        foreach (ops[i]) begin
            exec_model_inst.stackStep(ops[i]);
            check("stack address", {8'h00, spStep[i][15] ? sp : sp + 16'h0001}, {8'h00, stackAddr});
            sp = sp + spStep[i];
            check("stack pointer", {8'h00, sp}, {8'h00, stackPointer});
        end
        // ****************************************************************
        // Working registers, pointers and program address
        // ****************************************************************
        @(negedge clk);
        wr8 <= '{en: 1'b1, addr: 5'h05, data: 8'hA5};
        wr16 <= '{en: 1'b1, pair: 4'hD, data: 16'h0100};
        rdAddrA <= 5'h05;
        rdAddrB <= 5'h1B;
        rdPair <= 4'hD;
        @(negedge clk);
        wr8 <= '0;
        wr16 <= '{en: 1'b1, pair: 4'hF, data: 16'hABCD};
        check("opA", 24'h0000A5, {16'h0000, opA});
        check("opB", 24'h000001, {16'h0000, opB});
        check("op16", 24'h000100, {8'h00, op16});
        @(negedge clk);
        wr16 <= '0;
        readCheck("register in data space", 1'b0, 16'h0005, 1'b1, 8'hA5);
        readCheck("register via port", 1'b1, 16'h0005, 1'b0, 8'h00);
        readCheck("extended range", 1'b0, 16'h0060, 1'b0, 8'h00);
        foreach (ptrRows[i]) begin
            exec_model_inst.ptrStep(ptrRows[i].mode, ptrRows[i].disp);
            check("pointer address", {8'h00, ptrRows[i].addr}, {8'h00, ptrAddr});
            check("pointer value", {8'h00, ptrRows[i].x}, {8'h00, op16});
        end
        exec_model_inst.busWrite(1'b0, 16'h005B, 8'hFF);
        readCheck("page unused bits", 1'b0, 16'h005B, 1'b1, 8'((1 << PAGE_W) - 1));
        exec_model_inst.busWrite(1'b1, 16'h003B, 8'h03);
        exec_model_inst.pmStep(1'b1);
        check("extended program address", 24'h03ABCD, pmAddr);
        exec_model_inst.pmStep(1'b0);
        check("plain program address", 24'h00ABCD, pmAddr);
        report_and_stop();
    end
endmodule : cpu_flags_regfile_stack_tb
`default_nettype wire
